// ---- rtl/tpe_pkg.sv ----
// Summary of operation
// - Label unstable change sets group event bit
// - Remote defect change sets group event bit
// - Remote failure change sets group event bit
// - Reading event register clears it, acknowledging interrupt
// - TU3 mode forces all event bits zero
// - Absent tributary four reads event bits zero
// - Event bits latch regardless of interrupt enables
// - Report enable inserts error info into V5
// - Flag output follows group select during tributary
// - Strobe edge or counter write raises busy
// - Busy drops after all counters transfer, <10us
// - Block mode: FEBE codes 1-8 add one
// - Bit mode: FEBE codes 1-8 add value
// - Trigger write copies and clears accumulators
package tpe_pkg;
	localparam int          NUM_GROUPS      = 7;
	localparam int          CNT_W           = 11;
	localparam int          ADDR_W          = 12;
	// Printed offsets are word indices; byte address is four times
	localparam logic [8:0]  IDX_LABEL_EVT   = 9'h1fa;
	localparam logic [8:0]  IDX_RDI_EVT     = 9'h1fb;
	localparam logic [8:0]  IDX_RFI_EVT     = 9'h1fc;
	localparam logic [8:0]  IDX_INBAND_CFG  = 9'h1fd;
	localparam logic [8:0]  IDX_FLAG_CFG    = 9'h1fe;
	localparam logic [8:0]  IDX_STATUS      = 9'h1ff;
	localparam logic [8:0]  IDX_LABEL_MASK  = 9'h1f0;
	localparam logic [8:0]  IDX_RDI_MASK    = 9'h1f1;
	localparam logic [8:0]  IDX_RFI_MASK    = 9'h1f2;
	localparam logic [8:0]  IDX_ACC_TRIG    = 9'h1f3;
	localparam logic [2:0]  IDX_CNT_TOP     = 3'b111;
	localparam logic [1:0]  CNT_BIP_LSB     = 2'h0;
	localparam logic [1:0]  CNT_BIP_MSB     = 2'h1;
	localparam logic [1:0]  CNT_FEBE_LSB    = 2'h2;
	localparam logic [1:0]  CNT_FEBE_MSB    = 2'h3;
	localparam int          ST_BUSY_BIT     = 0;
	localparam int          ST_BLK_BIT      = 1;
	localparam logic [7:0]  ST_RW_MASK      = 8'hc2;
	localparam logic [7:0]  RST_BYTE        = 8'h00;
	localparam logic [1:0]  CFG_TU11        = 2'h3;
	localparam logic [3:0]  FEBE_MAX_CODE   = 4'h8;
	localparam int          V5_REI_BIT      = 3;
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;
	localparam int          CLK_MHZ         = 40;
	localparam int          XFER_LIMIT_US   = 10;
	localparam int          XFER_MAX_CYC    = XFER_LIMIT_US * CLK_MHZ;
	localparam logic [2:0]  LAST_GROUP      = 3'(NUM_GROUPS - 1);
	typedef enum {XFER_IDLE, XFER_COPY} tpe_xfer_type;
endpackage

// ---- rtl/tpe_regs.sv ----
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
module tpe_regs (
	input  wire logic                        clk_sys,
	input  wire logic                        rst,
	input  wire logic [tpe_pkg::ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [tpe_pkg::ADDR_W-1:0]  s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	input  wire logic                        tu3Mode,
	input  wire logic [13:0]                 groupConfig,
	input  wire logic [6:0]                  labelUnstableState,
	input  wire logic [6:0]                  remoteDefectState,
	input  wire logic [6:0]                  remoteFailureState,
	input  wire logic                        accumulate_strobe_in,
	input  wire logic                        tribValid,
	input  wire logic [2:0]                  tribGroup,
	input  wire logic [7:0]                  v5In,
	input  wire logic                        v5Valid,
	input  wire logic                        inbandErrIn,
	input  wire logic [1:0]                  bipErrNum,
	input  wire logic                        febeValid,
	input  wire logic [3:0]                  febeCode,
	output logic [7:0]                       v5Out,
	output logic                             v5ValidOut,
	output logic                             tributary_flag_output,
	output logic                             irq
);
	import tpe_pkg::*;

	////////////////////////////////////////////////////////////////////
	// Decode helpers
	function automatic logic [8:0] wordIndex(
		input logic [ADDR_W-1:0] addr
	);
		wordIndex = addr[10:2];
	endfunction

	function automatic logic isCounter(input logic [8:0] idx);
		isCounter = (idx[8:6] == IDX_CNT_TOP) && idx[2]
			&& (idx[5:3] != 3'h7);
	endfunction

	function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
		logic [8:0] idx;
		idx = wordIndex(addr);
		isMapped = (addr[ADDR_W-1] == 1'b0) && (isCounter(idx)
			|| (idx >= IDX_LABEL_MASK && idx <= IDX_STATUS));
	endfunction

	////////////////////////////////////////////////////////////////////
	// State
	logic [6:0]        labelEvt_q, rdiEvt_q, rfiEvt_q;
	logic [6:0]        labelEvt_d, rdiEvt_d, rfiEvt_d;
	logic [6:0]        labelMask_q, rdiMask_q, rfiMask_q;
	logic [6:0]        inbandCfg_q, flagCfg_q;
	logic [7:0]        statusRw_q;
	logic [6:0]        labelPrev_q, rdiPrev_q, rfiPrev_q;
	logic              strobeMeta_q, strobeSync_q, strobeOld_q;
	logic [CNT_W-1:0]  bipAcc_q  [NUM_GROUPS];
	logic [CNT_W-1:0]  febeAcc_q [NUM_GROUPS];
	logic [CNT_W-1:0]  bipHold_q [NUM_GROUPS];
	logic [CNT_W-1:0]  febeHold_q[NUM_GROUPS];
	tpe_xfer_type      xferState_q;
	logic [2:0]        xferGroup_q;
	logic              awHeld_q, wHeld_q;
	logic [ADDR_W-1:0] awAddr_q;
	logic [7:0]        wData_q;
	logic              wLane_q;

	////////////////////////////////////////////////////////////////////
	// Bus decode
	wire              doWrite   = awHeld_q && wHeld_q && !s_axi_bvalid;
	wire [8:0]        wIdx      = wordIndex(awAddr_q);
	wire              wOk       = isMapped(awAddr_q);
	wire              wEn       = doWrite && wOk && wLane_q;
	wire              doRead    = s_axi_arvalid && s_axi_arready;
	wire [8:0]        rIdx      = wordIndex(s_axi_araddr);
	wire              rOk       = isMapped(s_axi_araddr);
	wire              rdLabel   = doRead && rOk && rIdx == IDX_LABEL_EVT;
	wire              rdRdi     = doRead && rOk && rIdx == IDX_RDI_EVT;
	wire              rdRfi     = doRead && rOk && rIdx == IDX_RFI_EVT;
	wire              wrCounter = doWrite && wOk && isCounter(wIdx);
	wire              wrTrig    = wEn && wIdx == IDX_ACC_TRIG;

	////////////////////////////////////////////////////////////////////
	// Event detection
	wire [6:0] groupLive;
	genvar g;
	generate
		for (g = 0; g < NUM_GROUPS; g++) begin : gLive
			// Tributary four exists only in TU11 groups
			assign groupLive[g] = !tu3Mode
				&& groupConfig[2*g+1 -: 2] == CFG_TU11;
		end
	endgenerate

	wire [6:0] labelHit = (labelUnstableState ^ labelPrev_q) & groupLive;
	wire [6:0] rdiHit   = (remoteDefectState ^ rdiPrev_q) & groupLive;
	wire [6:0] rfiHit   = (remoteFailureState ^ rfiPrev_q) & groupLive;
	wire [6:0] wClr     = wLane_q ? wData_q[6:0] : 7'h00;

	// Set wins over clear so no change is lost on a read
	always_comb begin
		labelEvt_d = labelEvt_q;
		rdiEvt_d   = rdiEvt_q;
		rfiEvt_d   = rfiEvt_q;
		if (rdLabel)
			labelEvt_d = 7'h00;
		if (rdRdi)
			rdiEvt_d = 7'h00;
		if (rdRfi)
			rfiEvt_d = 7'h00;
		if (wEn && wIdx == IDX_LABEL_EVT)
			labelEvt_d = labelEvt_d & ~wClr;
		if (wEn && wIdx == IDX_RDI_EVT)
			rdiEvt_d = rdiEvt_d & ~wClr;
		if (wEn && wIdx == IDX_RFI_EVT)
			rfiEvt_d = rfiEvt_d & ~wClr;
		labelEvt_d = (labelEvt_d | labelHit) & groupLive;
		rdiEvt_d   = (rdiEvt_d | rdiHit) & groupLive;
		rfiEvt_d   = (rfiEvt_d | rfiHit) & groupLive;
	end

	// Masks only gate the output; events latch anyway
	wire irqNext = |(labelEvt_d & labelMask_q)
		| |(rdiEvt_d & rdiMask_q)
		| |(rfiEvt_d & rfiMask_q);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			labelEvt_q  <= 7'h00;
			rdiEvt_q    <= 7'h00;
			rfiEvt_q    <= 7'h00;
			labelPrev_q <= 7'h00;
			rdiPrev_q   <= 7'h00;
			rfiPrev_q   <= 7'h00;
			irq         <= 1'b0;
		end else begin
			labelEvt_q  <= labelEvt_d;
			rdiEvt_q    <= rdiEvt_d;
			rfiEvt_q    <= rfiEvt_d;
			labelPrev_q <= labelUnstableState;
			rdiPrev_q   <= remoteDefectState;
			rfiPrev_q   <= remoteFailureState;
			irq         <= irqNext;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Configuration registers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			labelMask_q <= RST_BYTE[6:0];
			rdiMask_q   <= RST_BYTE[6:0];
			rfiMask_q   <= RST_BYTE[6:0];
			inbandCfg_q <= RST_BYTE[6:0];
			flagCfg_q   <= RST_BYTE[6:0];
			statusRw_q  <= RST_BYTE;
		end else if (wEn) begin
			if (wIdx == IDX_LABEL_MASK)
				labelMask_q <= wData_q[6:0];
			if (wIdx == IDX_RDI_MASK)
				rdiMask_q <= wData_q[6:0];
			if (wIdx == IDX_RFI_MASK)
				rfiMask_q <= wData_q[6:0];
			if (wIdx == IDX_INBAND_CFG)
				inbandCfg_q <= wData_q[6:0];
			if (wIdx == IDX_FLAG_CFG)
				flagCfg_q <= wData_q[6:0];
			// Reserved bits dropped by ST_RW_MASK; only bits 7, 6 and 1 are stored
			if (wIdx == IDX_STATUS)
				statusRw_q <= wData_q & ST_RW_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Datapath: V5 insertion and flag output
	wire [2:0] grpIdx   = tribGroup - 3'h1;
	wire       grpOk    = tribGroup != 3'h0 && tribGroup <= 3'(NUM_GROUPS);
	wire       inbandOn = tribValid && grpOk && inbandCfg_q[grpIdx];
	wire [7:0] v5Ins    = {v5In[7:V5_REI_BIT+1], inbandErrIn,
		v5In[V5_REI_BIT-1:0]};

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			v5Out                 <= 8'h00;
			v5ValidOut            <= 1'b0;
			tributary_flag_output <= 1'b0;
		end else begin
			v5Out      <= inbandOn ? v5Ins : v5In;
			v5ValidOut <= v5Valid;
			// Low between tributaries
			tributary_flag_output <= tribValid && grpOk
				&& flagCfg_q[grpIdx];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Error accumulation and transfer
	wire       blockMode = statusRw_q[ST_BLK_BIT];
	wire       febeInRng = febeCode != 4'h0 && febeCode <= FEBE_MAX_CODE;
	wire [3:0] febeAdd   = !febeValid || !febeInRng ? 4'h0
		: blockMode ? 4'h1
		: febeCode;
	wire       xferBusy  = xferState_q == XFER_COPY;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			strobeMeta_q <= 1'b0;
			strobeSync_q <= 1'b0;
			strobeOld_q  <= 1'b0;
		end else begin
			strobeMeta_q <= accumulate_strobe_in;
			strobeSync_q <= strobeMeta_q;
			strobeOld_q  <= strobeSync_q;
		end
	end

	wire xferStart = (strobeSync_q && !strobeOld_q) || wrCounter
		|| wrTrig;

	// One group per cycle: seven cycles, far inside the limit
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			xferState_q <= XFER_IDLE;
			xferGroup_q <= 3'h0;
		end else begin
			case (xferState_q)
				XFER_IDLE: begin
					if (xferStart) begin
						xferState_q <= XFER_COPY;
						xferGroup_q <= 3'h0;
					end
				end
				XFER_COPY: begin
					if (xferGroup_q == LAST_GROUP)
						xferState_q <= XFER_IDLE;
					else
						xferGroup_q <= xferGroup_q + 3'h1;
				end
				default: xferState_q <= XFER_IDLE;
			endcase
		end
	end

	generate
		for (g = 0; g < NUM_GROUPS; g++) begin : gAcc
			wire here   = tribValid && grpOk && grpIdx == 3'(g);
			wire copyIt = xferBusy && xferGroup_q == 3'(g);
			wire [CNT_W-1:0] bipInc  = here ? CNT_W'(bipErrNum)
				: '0;
			wire [CNT_W-1:0] febeInc = here ? CNT_W'(febeAdd) : '0;
			// Counters wrap; no saturation
			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					bipAcc_q[g]   <= '0;
					febeAcc_q[g]  <= '0;
					bipHold_q[g]  <= '0;
					febeHold_q[g] <= '0;
				end else if (copyIt) begin
					bipHold_q[g]  <= bipAcc_q[g];
					febeHold_q[g] <= febeAcc_q[g];
					bipAcc_q[g]   <= bipInc;
					febeAcc_q[g]  <= febeInc;
				end else begin
					bipAcc_q[g]  <= bipAcc_q[g] + bipInc;
					febeAcc_q[g] <= febeAcc_q[g] + febeInc;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// Read mux
	wire [2:0]       cntGrp  = rIdx[5:3];
	wire [CNT_W-1:0] bipSel  = bipHold_q[cntGrp];
	wire [CNT_W-1:0] febeSel = febeHold_q[cntGrp];
	wire [7:0] statusRd = {statusRw_q[7:1], xferBusy};
	wire [7:0] cntRd =
		rIdx[1:0] == CNT_BIP_LSB  ? bipSel[7:0]
		: rIdx[1:0] == CNT_BIP_MSB  ? {5'h00, bipSel[CNT_W-1:8]}
		: rIdx[1:0] == CNT_FEBE_LSB ? febeSel[7:0]
		: {5'h00, febeSel[CNT_W-1:8]};
	wire [7:0] regRd =
		rIdx == IDX_LABEL_EVT  ? {1'b0, labelEvt_q & groupLive}
		: rIdx == IDX_RDI_EVT    ? {1'b0, rdiEvt_q & groupLive}
		: rIdx == IDX_RFI_EVT    ? {1'b0, rfiEvt_q & groupLive}
		: rIdx == IDX_INBAND_CFG ? {1'b0, inbandCfg_q}
		: rIdx == IDX_FLAG_CFG   ? {1'b0, flagCfg_q}
		: rIdx == IDX_LABEL_MASK ? {1'b0, labelMask_q}
		: rIdx == IDX_RDI_MASK   ? {1'b0, rdiMask_q}
		: rIdx == IDX_RFI_MASK   ? {1'b0, rfiMask_q}
		: rIdx == IDX_STATUS     ? statusRd
		: 8'h00;
	wire [7:0] rdByte = !rOk ? 8'h00 : isCounter(rIdx) ? cntRd : regRd;

	////////////////////////////////////////////////////////////////////
	// AXI4-Lite handshakes
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			awHeld_q      <= 1'b0;
			wHeld_q       <= 1'b0;
			awAddr_q      <= '0;
			wData_q       <= 8'h00;
			wLane_q       <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else begin
			s_axi_awready <= !awHeld_q && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready  <= !wHeld_q && !(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_q <= 1'b1;
				awAddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_q <= 1'b1;
				wData_q <= s_axi_wdata[7:0];
				wLane_q <= s_axi_wstrb[0];
			end
			if (doWrite) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wOk ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				awHeld_q      <= 1'b0;
				wHeld_q       <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else if (doRead) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= {24'h00_0000, rdByte};
			s_axi_rresp   <= rOk ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end else begin
			s_axi_arready <= !s_axi_rvalid;
		end
	end

endmodule

// ---- bench/tpe_regs_sva.sv ----
`timescale 1ns/1ps
module tpe_regs_sva (
	input wire logic				clk_sys,
	input wire logic				rst,
	input wire logic				s_axi_awvalid,
	input wire logic				s_axi_awready,
	input wire logic				s_axi_wvalid,
	input wire logic				s_axi_wready,
	input wire logic				s_axi_bvalid,
	input wire logic				s_axi_bready,
	input wire logic [tpe_pkg::ADDR_W-1:0]	s_axi_araddr,
	input wire logic				s_axi_arvalid,
	input wire logic				s_axi_arready,
	input wire logic				s_axi_rvalid,
	input wire logic				s_axi_rready,
	input wire logic [31:0]			s_axi_rdata,
	input wire logic				tu3Mode,
	input wire logic				tribValid,
	input wire logic [7:0]			v5In,
	input wire logic [7:0]			v5Out,
	input wire logic				v5ValidOut,
	input wire logic				tributary_flag_output,
	input wire logic				irq
);
	import tpe_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("read not answered next cycle");
	chk_write_answer: assert property (s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write response missing");
	chk_b_single: assert property (s_axi_bvalid && s_axi_bready
		|=> !s_axi_bvalid) else $error("write response repeated");
	chk_r_single: assert property (s_axi_rvalid && s_axi_rready
		|=> !s_axi_rvalid) else $error("read response repeated");
	chk_aw_blocked: assert property (s_axi_bvalid
		|-> !s_axi_awready && !s_axi_wready) else $error("second write open");
	// Address is sampled at the take edge, one before rvalid is seen
	chk_tu3_zero: assert property ($rose(s_axi_rvalid)
		&& $past(tu3Mode)
		&& $past(s_axi_araddr[10:2]) inside {[IDX_LABEL_EVT:IDX_RFI_EVT]}
		|-> s_axi_rdata == 32'h0) else $error("event read nonzero in TU3");
	chk_flag_slot: assert property (tributary_flag_output
		|-> $past(tribValid)) else $error("flag high outside slot");
	chk_v5_pass: assert property (v5ValidOut
		|-> v5Out[7:4] == $past(v5In[7:4])
		&& v5Out[2:0] == $past(v5In[2:0]))
		else $error("V5 bits other than report bit altered");
	cover property (irq);
	cover property (tributary_flag_output);
	cover property ($rose(s_axi_rvalid) && tu3Mode);
endmodule
bind tpe_regs tpe_regs_sva u_chk (.*);

// ---- bench/tb_tributary_path_event_regs.sv ----
`timescale 1ns/1ps
module tb_tributary_path_event_regs;
	import tpe_pkg::*;
	logic			clk_sys = 1'h0;
	logic			rst = 1'h1;
	logic [ADDR_W-1:0]	s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [31:0]		s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]		s_axi_wstrb = 4'h1;
	logic			s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
	logic			s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
	logic			s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
	logic			s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0]		s_axi_bresp, s_axi_rresp, bipErrNum = 2'h0;
	logic			tu3Mode = 1'h0, accumulate_strobe_in = 1'h0;
	logic [13:0]		groupConfig = 14'h3fff;
	logic [6:0]		labelUnstableState = 7'h0, remoteDefectState = 7'h0;
	logic [6:0]		remoteFailureState = 7'h0;
	logic			tribValid = 1'h0, v5Valid = 1'h0, inbandErrIn = 1'h0;
	logic [2:0]		tribGroup = 3'h0;
	logic [7:0]		v5In = 8'h0, v5Out;
	logic			febeValid = 1'h0, v5ValidOut, tributary_flag_output;
	logic [3:0]		febeCode = 4'h0;
	int			badCount = 0, checked = 0, cyc = 0;

	tpe_regs DUT (.*);

	initial forever #12.5 clk_sys = ~clk_sys;
	////////////////////////////////////////////////////////////////////////
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			badCount++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic completeRun();
		$display("checked=%0d mismatches=%0d", checked, badCount);
		if (badCount == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// Ready is looked at mid-cycle so the handshake edge is never raced
	task automatic wr(input logic [8:0] idx, input logic [7:0] dat,
		input logic [1:0] er = RESP_OKAY);
		logic a, w;
		logic b = 1'h0;
		logic [1:0] r;
		@(posedge clk_sys);
		s_axi_awaddr <= {1'h0, idx, 2'h0};
		s_axi_wdata <= {24'h0, dat};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		// Only bvalid or the bench timeout ends this wait
		while (!b) begin
			@(negedge clk_sys);
			a = s_axi_awready;
			w = s_axi_wready;
			b = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge clk_sys);
			if (a) s_axi_awvalid <= 1'h0;
			if (w) s_axi_wvalid <= 1'h0;
			if (b) s_axi_bready <= 1'h0;
		end
		cmp({30'h0, r}, {30'h0, er});
	endtask

	task automatic rd(input logic [8:0] idx, output logic [31:0] d,
		output logic [1:0] r);
		logic a;
		logic v = 1'h0;
		@(posedge clk_sys);
		s_axi_araddr <= {1'h0, idx, 2'h0};
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		while (!v) begin
			@(negedge clk_sys);
			a = s_axi_arready;
			v = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge clk_sys);
			if (a) s_axi_arvalid <= 1'h0;
			if (v) s_axi_rready <= 1'h0;
		end
	endtask

	task automatic rx(input logic [8:0] idx, input logic [7:0] e,
		input logic [1:0] er = RESP_OKAY);
		logic [31:0] d;
		logic [1:0] r;
		rd(idx, d, r);
		cmp(d, {24'h0, e});
		cmp({30'h0, r}, {30'h0, er});
	endtask

	// Ends on a rising edge so the next stimulus lands on it
	task automatic chkIrq(input logic e);
		@(negedge clk_sys);
		cmp({31'h0, irq}, {31'h0, e});
		@(posedge clk_sys);
	endtask

	// Polling costs about three cycles a read, well inside the limit
	task automatic waitIdle();
		logic [31:0] d;
		logic [1:0] r;
		int t0;
		t0 = cyc;
		do begin
			rd(IDX_STATUS, d, r);
		end while (d[0] !== 1'h0);
		cmp({31'h0, d[0]}, 32'h0);
		cmp({31'h0, (cyc - t0) > XFER_MAX_CYC}, 32'h0);
	endtask

	task automatic feed(input logic [3:0] c1, input logic [3:0] c2,
		input logic [1:0] bip);
		@(posedge clk_sys);
		tribValid <= 1'h1;
		tribGroup <= 3'h1;
		bipErrNum <= bip;
		febeValid <= 1'h1;
		febeCode <= c1;
		@(posedge clk_sys);
		bipErrNum <= 2'h0;
		febeCode <= c2;
		@(posedge clk_sys);
		tribValid <= 1'h0;
		febeValid <= 1'h0;
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic scnRegs();
		for (int i = 0; i < 6; i++)
			rx(IDX_LABEL_EVT + 9'(i), 8'h00);
		wr(IDX_INBAND_CFG, 8'h7f);
		rx(IDX_INBAND_CFG, 8'h7f);
		wr(IDX_FLAG_CFG, 8'h2a);
		rx(IDX_FLAG_CFG, 8'h2a);
		rx(9'h100, 8'h00, RESP_SLVERR);
		wr(9'h100, 8'h55, RESP_SLVERR);
	endtask

	task automatic scnEvents();
		@(posedge clk_sys);
		labelUnstableState <= 7'h41;
		remoteDefectState <= 7'h08;
		remoteFailureState <= 7'h20;
		step(3);
		chkIrq(1'h0);
		rx(IDX_LABEL_EVT, 8'h41);
		rx(IDX_RDI_EVT, 8'h08);
		rx(IDX_RFI_EVT, 8'h20);
		rx(IDX_LABEL_EVT, 8'h00);
		rx(IDX_RDI_EVT, 8'h00);
		wr(IDX_LABEL_MASK, 8'h40);
		labelUnstableState <= 7'h40;
		step(3);
		chkIrq(1'h0);
		labelUnstableState <= 7'h00;
		step(3);
		chkIrq(1'h1);
		rx(IDX_LABEL_EVT, 8'h41);
		step(2);
		chkIrq(1'h0);
	endtask

	task automatic scnAbsent();
		@(posedge clk_sys);
		groupConfig <= 14'h3ff3;
		labelUnstableState <= 7'h7f;
		step(3);
		rx(IDX_LABEL_EVT, 8'h7d);
		tu3Mode <= 1'h1;
		remoteFailureState <= 7'h5f;
		step(3);
		rx(IDX_RFI_EVT, 8'h00);
		tu3Mode <= 1'h0;
		groupConfig <= 14'h3fff;
	endtask

	task automatic scnDatapath();
		wr(IDX_FLAG_CFG, 8'h05);
		wr(IDX_INBAND_CFG, 8'h01);
		@(posedge clk_sys);
		tribValid <= 1'h1;
		tribGroup <= 3'h1;
		v5Valid <= 1'h1;
		v5In <= 8'hf0;
		inbandErrIn <= 1'h1;
		@(posedge clk_sys);
		tribGroup <= 3'h2;
		v5In <= 8'h07;
		@(negedge clk_sys);
		cmp({31'h0, tributary_flag_output}, 32'h1);
		cmp({24'h0, v5Out}, 32'hf8);
		cmp({31'h0, v5ValidOut}, 32'h1);
		@(posedge clk_sys);
		tribValid <= 1'h0;
		tribGroup <= 3'h1;
		v5Valid <= 1'h0;
		v5In <= 8'hf0;
		@(negedge clk_sys);
		cmp({31'h0, tributary_flag_output}, 32'h0);
		cmp({24'h0, v5Out}, 32'h07);
		cmp({31'h0, v5ValidOut}, 32'h1);
		// Enabled group outside its slot: no insertion, flag low
		@(negedge clk_sys);
		cmp({31'h0, tributary_flag_output}, 32'h0);
		cmp({24'h0, v5Out}, 32'hf0);
		cmp({31'h0, v5ValidOut}, 32'h0);
	endtask

	task automatic scnCounts();
		wr(IDX_STATUS, 8'h00);
		feed(4'h5, 4'h9, 2'h2);
		wr(IDX_ACC_TRIG, 8'h01);
		waitIdle();
		rx(9'h1c4, 8'h02);
		rx(9'h1c6, 8'h05);
		wr(IDX_STATUS, 8'h02);
		feed(4'h7, 4'h0, 2'h0);
		accumulate_strobe_in <= 1'h1;
		step(4);
		rx(IDX_STATUS, 8'h03);
		accumulate_strobe_in <= 1'h0;
		waitIdle();
		rx(9'h1c6, 8'h01);
		rx(9'h1c4, 8'h00);
		wr(9'h1c4, 8'h00);
		rx(IDX_STATUS, 8'h03);
		waitIdle();
	endtask
	////////////////////////////////////////////////////////////////////////
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 3000) begin
			badCount++;
			completeRun();
		end
	end

	initial begin
		repeat (20) @(posedge clk_sys);
		rst <= 1'h0;
		step(2);
		scnRegs();
		scnEvents();
		scnAbsent();
		scnDatapath();
		scnCounts();
		completeRun();
	end
endmodule
